/* common/asp_pkg.sv */
package asp_pkg;
	// Register byte addresses, one aligned word each, data in bits 7..0.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_FMT     = 8'h04;
	localparam logic [7:0] OFS_BAUD_LO = 8'h08;
	localparam logic [7:0] OFS_BAUD_HI = 8'h0c;
	localparam logic [7:0] OFS_TXDATA  = 8'h10;
	localparam logic [7:0] OFS_RXDATA  = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_INTEN   = 8'h1c;
	localparam logic [7:0] OFS_RXEMU   = 8'h20;
	localparam logic [7:0] OFS_WAKE    = 8'h24;
	// Control register fields.
	localparam int CTRL_TX_EN    = 0;
	localparam int CTRL_RX_EN    = 1;
	localparam int CTRL_PAR_EN   = 2;
	localparam int CTRL_PAR_EVEN = 3;
	localparam int CTRL_TWO_STOP = 4;
	localparam int CTRL_ADDR_MD  = 5;
	localparam int CTRL_SLEEP    = 6;
	localparam int CTRL_AUTOBAUD = 7;
	// Format register: bits 2..0 hold data length minus one, bit 3 the address mark to send.
	localparam int FMT_TX_ADDR = 3;
	// Status register fields.
	localparam int ST_TX_BUFFER_READY_FLAG  = 0;
	localparam int ST_TXEMPT = 1;
	localparam int ST_RX_BUFFER_READY_FLAG  = 2;
	localparam int ST_BRK    = 3;
	localparam int ST_PE     = 4;
	localparam int ST_OE     = 5;
	localparam int ST_FE     = 6;
	localparam int ST_RXERR  = 7;
	// Interrupt enable fields.
	localparam int IE_TX = 0;
	localparam int IE_RX = 1;
	// Values after reset and timing.
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  FMT_RST   = 8'h07;
	localparam int          CLK_HZ    = 125_000_000;
	localparam int          BAUD_DEF  = 115_200;
	localparam logic [15:0] BAUD_RST  = 16'(CLK_HZ / BAUD_DEF - 1);
	localparam logic [3:0]  IDLE_BITS = 4'ha;
	localparam int          FIFO_DEF  = 16;
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
		TX_ADDR = 6'h08, TX_PAR = 6'h10, TX_STOP = 6'h20
	} asp_tx_st_t;
	typedef enum logic [6:0] {
		RX_IDLE = 7'h01, RX_START = 7'h02, RX_DATA = 7'h04, RX_ADDR = 7'h08,
		RX_PAR = 7'h10, RX_STOP = 7'h20, RX_HOLD = 7'h40
	} asp_rx_st_t;
endpackage

/* logic/asp_top.sv */
// Behaviour
// - sixteen-entry FIFOs for transmit and receive.
// - transmitter and receiver enabled independently.
// - check break, parity, overrun, framing per character.
// - bit time from 16-bit divisor.
// - one start, 1-8 data, parity, 1-2 stop.
// - even, odd or no parity.
// - idle-line and address-bit wakeup modes.
// - holding buffers separate from shift registers.
// - transmit-ready flag when holding buffer has room.
// - transmitter-empty flag when shifter idle.
// - receive-ready flag when character waiting.
// - break flag on break condition.
// - summary flag of four receive errors.
// - separate TX/RX interrupt enables, break ungated.
// - NRZ two-wire link, no shared clock.
// - automatic baud detection hardware.
// - eight-bit registers, upper bits read zero.
// - shifter loads from buffer, shifts out serially.
// - completed character to buffer and emulation copy.
//
// The APB register port and the placing of the registers were chosen for this implementation.
module asp_top
	import asp_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_rx_pin,
	output logic             serial_tx_pin,
	output logic             tx_int,
	output logic             rx_int
);
	localparam int PW = $clog2(FIFO_DEPTH);

	// Pointer arithmetic below relies on a power-of-two depth.
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 || (1 << PW) != FIFO_DEPTH) begin : g_chk
		$error("FIFO_DEPTH must be a power of two from 2 to 256.");
	end

	// Parity bit that makes the data plus parity even or odd.
	function automatic logic par_of(input logic [7:0] d, input logic even);
		par_of = even ? ^d : ~^d;
	endfunction

	// Register and FIFO state.
	logic [7:0]  ctrl_r, ctrl_nxt, fmt_r, fmt_nxt, inten_r, inten_nxt, emu_r, emu_nxt;
	logic [15:0] baud_r, baud_nxt;
	logic [3:0]  err_r, err_nxt;
	logic        wake_r, wake_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic        tx_int_r, tx_int_nxt, rx_int_r, rx_int_nxt;
	logic [7:0]  tx_mem [FIFO_DEPTH];
	logic [8:0]  rx_mem [FIFO_DEPTH];
	logic [PW:0] txw_r, txw_nxt, txr_r, txr_nxt, rxw_r, rxw_nxt, rxr_r, rxr_nxt;
	logic [PW:0] tx_cnt, rx_cnt;
	logic        tx_push, rx_push, acc, rd, wr, mapped, accept;
	logic [7:0]  rd_byte;
	// Transmit state.
	asp_tx_st_t  tx_st_r, tx_st_nxt;
	logic [15:0] txc_r, txc_nxt;
	logic [7:0]  txsh_r, txsh_nxt;
	logic [2:0]  txb_r, txb_nxt;
	logic        txpar_r, txpar_nxt, txa_r, txa_nxt, txs2_r, txs2_nxt, txpin_r, txpin_nxt;
	logic        tx_load;
	// Receive state.
	asp_rx_st_t  rx_st_r, rx_st_nxt;
	logic [15:0] rxc_r, rxc_nxt, idc_r, idc_nxt;
	logic [7:0]  rxsh_r, rxsh_nxt;
	logic [2:0]  rxb_r, rxb_nxt;
	logic [3:0]  idb_r, idb_nxt;
	logic [16:0] ab_r, ab_nxt;
	logic        rxacc_r, rxacc_nxt, rxz_r, rxz_nxt, rxa_r, rxa_nxt, rxpe_r, rxpe_nxt;
	logic        aft_r, aft_nxt;
	logic        rx_done, rx_fe, rx_brk, ab_done;
	logic [7:0]  rx_data;

	assign tx_cnt = txw_r - txr_r;
	assign rx_cnt = rxw_r - rxr_r;

	// Bus decode, register writes, FIFO pointers and status flags.
	always_comb begin
		ctrl_nxt    = ctrl_r;
		fmt_nxt     = fmt_r;
		inten_nxt   = inten_r;
		baud_nxt    = baud_r;
		emu_nxt     = emu_r;
		wake_nxt    = wake_r;
		txw_nxt     = txw_r;
		txr_nxt     = txr_r;
		rxw_nxt     = rxw_r;
		rxr_nxt     = rxr_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		pready_nxt  = psel & penable & ~pready_r;
		acc         = psel & penable & pready_r;
		wr          = acc & pwrite & pstrb[0];
		rd          = acc & ~pwrite;
		mapped      = 1'b1;
		rd_byte     = 8'h00;
		if (paddr == OFS_CTRL) begin
			rd_byte = ctrl_r;
		end else if (paddr == OFS_FMT) begin
			rd_byte = fmt_r;
		end else if (paddr == OFS_BAUD_LO) begin
			rd_byte = baud_r[7:0];
		end else if (paddr == OFS_BAUD_HI) begin
			rd_byte = baud_r[15:8];
		end else if (paddr == OFS_TXDATA) begin
			rd_byte = 8'h00;
		end else if (paddr == OFS_RXDATA) begin
			rd_byte = (rx_cnt != '0) ? rx_mem[rxr_r[PW-1:0]][7:0] : emu_r;
		end else if (paddr == OFS_STATUS) begin
			rd_byte = {|err_r, err_r, rx_cnt != '0, tx_st_r == TX_IDLE,
				tx_cnt != (PW+1)'(FIFO_DEPTH)};
		end else if (paddr == OFS_INTEN) begin
			rd_byte = inten_r;
		end else if (paddr == OFS_RXEMU) begin
			rd_byte = emu_r;
		end else if (paddr == OFS_WAKE) begin
			rd_byte = {6'h00, idb_r == IDLE_BITS, wake_r};
		end else begin
			mapped = 1'b0;
		end
		// The error stands with pready only; read data holds until the next read answer.
		if (pready_nxt) begin
			pslverr_nxt = ~mapped;
		end
		if (pready_nxt && !pwrite) begin
			prdata_nxt = {24'h000000, rd_byte};
		end
		if (wr && paddr == OFS_CTRL) begin
			ctrl_nxt = pwdata[7:0];
		end
		if (wr && paddr == OFS_FMT) begin
			fmt_nxt = {4'h0, pwdata[3:0]};
		end
		if (wr && paddr == OFS_BAUD_LO) begin
			baud_nxt[7:0] = pwdata[7:0];
		end
		if (wr && paddr == OFS_BAUD_HI) begin
			baud_nxt[15:8] = pwdata[7:0];
		end
		if (wr && paddr == OFS_INTEN) begin
			inten_nxt = {6'h00, pwdata[1:0]};
		end
		// Autobaud result replaces the divisor and ends the measurement.
		if (ab_done) begin
			baud_nxt = ab_r[16] ? 16'hffff : ab_r[15:0];
			ctrl_nxt[CTRL_AUTOBAUD] = 1'b0;
		end
		// Transmit FIFO: pushes beyond full are dropped.
		tx_push = wr && paddr == OFS_TXDATA && tx_cnt != (PW+1)'(FIFO_DEPTH);
		if (tx_push) begin
			txw_nxt = txw_r + 1'b1;
		end
		if (tx_load) begin
			txr_nxt = txr_r + 1'b1;
		end
		// Receive FIFO pop on data read.
		if (rd && paddr == OFS_RXDATA && rx_cnt != '0) begin
			rxr_nxt = rxr_r + 1'b1;
		end
		// In sleep only an address-marked (address mode) or post-idle (idle-line mode) character is taken; sleep stays set.
		accept  = ~ctrl_r[CTRL_SLEEP] | (ctrl_r[CTRL_ADDR_MD] ? rxa_r : aft_r);
		rx_push = rx_done & accept & (rx_cnt != (PW+1)'(FIFO_DEPTH));
		if (rx_push) begin
			rxw_nxt  = rxw_r + 1'b1;
			emu_nxt  = rx_data;
			wake_nxt = ctrl_r[CTRL_ADDR_MD] ? rxa_r : aft_r;
		end
		// Error flags: write one to clear, a new event wins over the clear.
		err_nxt = err_r & ~((wr && paddr == OFS_STATUS) ? pwdata[ST_FE:ST_BRK] : 4'h0);
		err_nxt = err_nxt | {rx_done & accept & rx_fe,
			rx_done & accept & (rx_cnt == (PW+1)'(FIFO_DEPTH)),
			rx_done & accept & rxpe_r, rx_done & rx_brk};
		// Interrupt requests, break drives the receive request without an enable.
		tx_int_nxt = inten_r[IE_TX] & (tx_cnt != (PW+1)'(FIFO_DEPTH));
		rx_int_nxt = (inten_r[IE_RX] & ((rx_cnt != '0) | (|err_r))) | err_r[0];
	end

	// Register and FIFO flip-flops.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_r    <= CTRL_RST;
			fmt_r     <= FMT_RST;
			inten_r   <= 8'h00;
			baud_r    <= BAUD_RST;
			emu_r     <= 8'h00;
			wake_r    <= 1'b0;
			err_r     <= 4'h0;
			txw_r     <= '0;
			txr_r     <= '0;
			rxw_r     <= '0;
			rxr_r     <= '0;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			tx_int_r  <= 1'b0;
			rx_int_r  <= 1'b0;
		end else if (ce) begin
			ctrl_r    <= ctrl_nxt;
			fmt_r     <= fmt_nxt;
			inten_r   <= inten_nxt;
			baud_r    <= baud_nxt;
			emu_r     <= emu_nxt;
			wake_r    <= wake_nxt;
			err_r     <= err_nxt;
			txw_r     <= txw_nxt;
			txr_r     <= txr_nxt;
			rxw_r     <= rxw_nxt;
			rxr_r     <= rxr_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			tx_int_r  <= tx_int_nxt;
			rx_int_r  <= rx_int_nxt;
			if (tx_push) begin
				tx_mem[txw_r[PW-1:0]] <= pwdata[7:0];
			end
			if (rx_push) begin
				rx_mem[rxw_r[PW-1:0]] <= {rxa_r, rx_data};
			end
		end
	end

	// Transmitter: one bit time is baud + 1 clocks.
	always_comb begin
		tx_st_nxt = tx_st_r;
		txsh_nxt  = txsh_r;
		txb_nxt   = txb_r;
		txpar_nxt = txpar_r;
		txa_nxt   = txa_r;
		txs2_nxt  = txs2_r;
		txpin_nxt = txpin_r;
		txc_nxt   = (txc_r == 16'h0000) ? baud_r : txc_r - 16'h0001;
		tx_load   = 1'b0;
		case (tx_st_r)
			TX_IDLE: begin
				txpin_nxt = 1'b1;
				if (ctrl_r[CTRL_TX_EN] && tx_cnt != '0) begin
					tx_load   = 1'b1;
					txsh_nxt  = tx_mem[txr_r[PW-1:0]];
					txpar_nxt = par_of(tx_mem[txr_r[PW-1:0]] & (8'hff >> (3'h7 - fmt_r[2:0])),
						ctrl_r[CTRL_PAR_EVEN]);
					txa_nxt   = fmt_r[FMT_TX_ADDR];
					txs2_nxt  = ctrl_r[CTRL_TWO_STOP];
					txc_nxt   = baud_r;
					txpin_nxt = 1'b0;
					tx_st_nxt = TX_START;
				end
			end
			TX_START: begin
				if (txc_r == 16'h0000) begin
					txpin_nxt = txsh_r[0];
					txb_nxt   = 3'h0;
					tx_st_nxt = TX_DATA;
				end
			end
			TX_DATA: begin
				if (txc_r == 16'h0000) begin
					txsh_nxt  = txsh_r >> 1;
					txpin_nxt = txsh_r[1];
					txb_nxt   = txb_r + 3'h1;
					if (txb_r == fmt_r[2:0]) begin
						if (ctrl_r[CTRL_ADDR_MD]) begin
							txpin_nxt = txa_r;
							tx_st_nxt = TX_ADDR;
						end else if (ctrl_r[CTRL_PAR_EN]) begin
							txpin_nxt = txpar_r;
							tx_st_nxt = TX_PAR;
						end else begin
							txpin_nxt = 1'b1;
							tx_st_nxt = TX_STOP;
						end
					end
				end
			end
			TX_ADDR: begin
				if (txc_r == 16'h0000) begin
					txpin_nxt = ctrl_r[CTRL_PAR_EN] ? txpar_r : 1'b1;
					tx_st_nxt = ctrl_r[CTRL_PAR_EN] ? TX_PAR : TX_STOP;
				end
			end
			TX_PAR: begin
				if (txc_r == 16'h0000) begin
					txpin_nxt = 1'b1;
					tx_st_nxt = TX_STOP;
				end
			end
			default: begin
				if (txc_r == 16'h0000) begin
					txs2_nxt  = 1'b0;
					tx_st_nxt = txs2_r ? TX_STOP : TX_IDLE;
				end
			end
		endcase
	end

	// Transmitter flip-flops.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_st_r <= TX_IDLE;
			txc_r   <= 16'h0000;
			txsh_r  <= 8'h00;
			txb_r   <= 3'h0;
			txpar_r <= 1'b0;
			txa_r   <= 1'b0;
			txs2_r  <= 1'b0;
			txpin_r <= 1'b1;
		end else if (ce) begin
			tx_st_r <= tx_st_nxt;
			txc_r   <= txc_nxt;
			txsh_r  <= txsh_nxt;
			txb_r   <= txb_nxt;
			txpar_r <= txpar_nxt;
			txa_r   <= txa_nxt;
			txs2_r  <= txs2_nxt;
			txpin_r <= txpin_nxt;
		end
	end

	// Receiver: samples mid-bit, counts idle bit times, measures autobaud.
	always_comb begin
		rx_st_nxt = rx_st_r;
		rxsh_nxt  = rxsh_r;
		rxb_nxt   = rxb_r;
		rxacc_nxt = rxacc_r;
		rxz_nxt   = rxz_r;
		rxa_nxt   = rxa_r;
		rxpe_nxt  = rxpe_r;
		aft_nxt   = aft_r;
		idc_nxt   = idc_r;
		idb_nxt   = idb_r;
		ab_nxt    = ab_r;
		ab_done   = 1'b0;
		rx_done   = 1'b0;
		rx_fe     = ~serial_rx_pin;
		rx_brk    = rxz_r & ~serial_rx_pin;
		rx_data   = rxsh_r >> (3'h7 - fmt_r[2:0]);
		rxc_nxt   = (rxc_r == 16'h0000) ? baud_r : rxc_r - 16'h0001;
		case (rx_st_r)
			RX_IDLE: begin
				// Line high: count whole idle bit times up to the idle threshold.
				if (serial_rx_pin && idb_r != IDLE_BITS) begin
					idc_nxt = (idc_r == 16'h0000) ? baud_r : idc_r - 16'h0001;
					if (idc_r == 16'h0000) begin
						idb_nxt = idb_r + 4'h1;
					end
				end
				if (ctrl_r[CTRL_AUTOBAUD]) begin
					// Start bit width of the first character gives the bit time.
					if (!serial_rx_pin) begin
						ab_nxt = (ab_r == 17'h1ffff) ? ab_r : ab_r + 17'h00001;
					end else if (ab_r != 17'h00000) begin
						ab_done = 1'b1;
						ab_nxt  = 17'h00000;
						rx_st_nxt = RX_HOLD;
					end
				end else if (ctrl_r[CTRL_RX_EN] && !serial_rx_pin) begin
					aft_nxt   = idb_r == IDLE_BITS;
					idb_nxt   = 4'h0;
					idc_nxt   = baud_r;
					rxc_nxt   = baud_r >> 1;
					rx_st_nxt = RX_START;
				end
			end
			RX_START: begin
				if (rxc_r == 16'h0000) begin
					rxb_nxt   = 3'h0;
					rxacc_nxt = 1'b0;
					rxz_nxt   = 1'b1;
					rxa_nxt   = 1'b0;
					rxpe_nxt  = 1'b0;
					rx_st_nxt = serial_rx_pin ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rxc_r == 16'h0000) begin
					rxsh_nxt  = {serial_rx_pin, rxsh_r[7:1]};
					rxacc_nxt = rxacc_r ^ serial_rx_pin;
					rxz_nxt   = rxz_r & ~serial_rx_pin;
					rxb_nxt   = rxb_r + 3'h1;
					if (rxb_r == fmt_r[2:0]) begin
						rx_st_nxt = ctrl_r[CTRL_ADDR_MD] ? RX_ADDR :
							(ctrl_r[CTRL_PAR_EN] ? RX_PAR : RX_STOP);
					end
				end
			end
			RX_ADDR: begin
				if (rxc_r == 16'h0000) begin
					rxa_nxt   = serial_rx_pin;
					rxz_nxt   = rxz_r & ~serial_rx_pin;
					rx_st_nxt = ctrl_r[CTRL_PAR_EN] ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: begin
				if (rxc_r == 16'h0000) begin
					rxpe_nxt  = par_of({7'h00, rxacc_r}, ctrl_r[CTRL_PAR_EVEN])
						!= serial_rx_pin;
					rxz_nxt   = rxz_r & ~serial_rx_pin;
					rx_st_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rxc_r == 16'h0000) begin
					rx_done   = 1'b1;
					rx_st_nxt = RX_HOLD;
				end
			end
			default: begin
				// Wait for the line to return high, so a long break reports once.
				if (serial_rx_pin) begin
					rx_st_nxt = RX_IDLE;
				end
			end
		endcase
	end

	// Receiver flip-flops.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_st_r <= RX_IDLE;
			rxc_r   <= 16'h0000;
			idc_r   <= 16'h0000;
			rxsh_r  <= 8'h00;
			rxb_r   <= 3'h0;
			idb_r   <= 4'h0;
			ab_r    <= 17'h00000;
			rxacc_r <= 1'b0;
			rxz_r   <= 1'b0;
			rxa_r   <= 1'b0;
			rxpe_r  <= 1'b0;
			aft_r   <= 1'b0;
		end else if (ce) begin
			rx_st_r <= rx_st_nxt;
			rxc_r   <= rxc_nxt;
			idc_r   <= idc_nxt;
			rxsh_r  <= rxsh_nxt;
			rxb_r   <= rxb_nxt;
			idb_r   <= idb_nxt;
			ab_r    <= ab_nxt;
			rxacc_r <= rxacc_nxt;
			rxz_r   <= rxz_nxt;
			rxa_r   <= rxa_nxt;
			rxpe_r  <= rxpe_nxt;
			aft_r   <= aft_nxt;
		end
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign serial_tx_pin = txpin_r;
	assign tx_int        = tx_int_r;
	assign rx_int        = rx_int_r;
endmodule

/* test/asp_monitor.sv */
module asp_monitor
	import asp_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_tx_pin,
	input wire logic        tx_int,
	input wire logic        rx_int
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mapped;
	// Registers sit on every fourth byte from the control word up to the wake word.
	assign mapped = (paddr <= OFS_WAKE) && (paddr[1:0] == 2'b00);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// A request latched at its first access edge, and the answer that ends it.
	sequence s_take;
		psel && penable && !pready && ce;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	a_ready_one_wait: assert property (s_take |=> pready)
		else $error("answer missing one cycle after the access edge");
	a_ready_pulse: assert property (pready && ce |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_decode: assert property (s_answer |-> (pslverr == !mapped))
		else $error("error response does not match the address decode");
	a_err_with_ready: assert property (pslverr |-> s_answer)
		else $error("error response outside an answered access");
	a_upper_zero: assert property (s_answer ##0 !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_rdata_hold: assert property (!(pready && !pwrite) |-> $stable(prdata))
		else $error("read data changed without a read answer");
	a_reset_idle: assert property ($fell(srst) |-> serial_tx_pin && !tx_int && !rx_int)
		else $error("line or interrupts not idle after reset");
endmodule

bind asp_top asp_monitor i_mon (
	.ref_clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .serial_tx_pin, .tx_int, .rx_int
);

/* test/asp_far_end.sv */
module asp_far_end (
	input  wire logic ref_clk,
	output logic      line_to_dut,
	input  wire logic line_from_dut
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bit_clks = 8;
	int         len      = 8;
	logic       par_on   = 1'b0;
	logic       par_even = 1'b0;
	logic       addr_on  = 1'b0;
	logic [9:0] got_q[$];
	logic [7:0] rd;
	logic       rp;
	initial line_to_dut = 1'b1;
	// Holds one bit for a whole bit time, changed just after a clock edge.
	task automatic bit_out(input logic b);
		line_to_dut <= b;
		repeat (bit_clks) @(posedge ref_clk);
	endtask
	// Sends one frame; flip spoils the parity and stop may be forced low.
	task automatic send(input logic [7:0] d, input logic abit, input logic flip, input logic stop);
		logic [7:0] m;
		m = d & (8'hff >> (8 - len));
		bit_out(1'b0);
		for (int i = 0; i < len; i++) begin
			bit_out(m[i]);
		end
		if (addr_on) begin
			bit_out(abit);
		end
		if (par_on) begin
			bit_out(^m ^ !par_even ^ flip);
		end
		bit_out(stop);
		bit_out(1'b1);
	endtask
	// Decodes each frame from the device, sampling every bit in its middle.
	always begin
		@(negedge line_from_dut);
		rd = 8'h00;
		rp = 1'b0;
		repeat (bit_clks / 2) @(posedge ref_clk);
		for (int i = 0; i < len; i++) begin
			repeat (bit_clks) @(posedge ref_clk);
			rd[i] = line_from_dut;
		end
		if (addr_on) begin
			repeat (bit_clks) @(posedge ref_clk);
			rp = line_from_dut;
		end
		if (par_on) begin
			repeat (bit_clks) @(posedge ref_clk);
			rp = line_from_dut;
		end
		repeat (bit_clks) @(posedge ref_clk);
		got_q.push_back({line_from_dut, rp, rd});
	end
endmodule

/* test/asp_top_tb.sv */
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module asp_top_tb
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk  = 1'b0;
	logic        srst     = 1'b1;
	logic        ce       = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [3:0]  pstrb    = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serial_rx_pin;
	logic        serial_tx_pin;
	logic        tx_int;
	logic        rx_int;
	logic [31:0] seed     = 32'h7bcd;
	logic [31:0] q;
	logic        last_err;
	logic [7:0]  m;
	logic [7:0]  tx_d;
	logic [7:0]  rx_d;
	logic [7:0]  dat[17];
	logic [7:0]  err_st[3] = '{8'h97, 8'hc7, 8'hcf};
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          cyc        = 0;

	asp_top #(.FIFO_DEPTH(16)) i_dut (
		.ref_clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .serial_rx_pin, .serial_tx_pin, .tx_int, .rx_int
	);
	asp_far_end i_far (.ref_clk, .line_to_dut(serial_rx_pin), .line_from_dut(serial_tx_pin));

	// Free-running clock of 8 ns.
	initial forever #4 ref_clk = ~ref_clk;

	// Cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// Xorshift source with a fixed start.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Frame as the far end records it: stop, parity, data.
	function automatic logic [9:0] exp_frame(input logic [7:0] d, input logic pon, input logic ev);
		return {1'b1, pon & (^d ^ !ev), d};
	endfunction

	// One APB transfer, held until ready is sampled high, then one idle cycle.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q        = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("register read", e, q)
	endtask

	task automatic wait_q(input int n);
		while (i_far.got_q.size() < n) begin
			@(posedge ref_clk);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence: reset values, framing sweep, errors, queues, wakeup, baud detection.
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		chk_rd(OFS_CTRL, 32'h00);
		chk_rd(OFS_FMT, 32'h07);
		chk_rd(OFS_BAUD_LO, 32'h3c);
		chk_rd(OFS_BAUD_HI, 32'h04);
		chk_rd(OFS_INTEN, 32'h00);
		chk_rd(OFS_STATUS, 32'h03);
		chk_rd(8'h28, 32'h00);
		`CHK("unmapped error", 1'b1, last_err)
		apb(1'b1, OFS_FMT, 32'habcd_e00d);
		pstrb <= 4'he;
		apb(1'b1, OFS_FMT, 32'h02);
		pstrb <= 4'hf;
		chk_rd(OFS_FMT, 32'h0d);
		apb(1'b1, OFS_BAUD_LO, 32'h07);
		apb(1'b1, OFS_BAUD_HI, 32'h00);
		chk_rd(OFS_BAUD_LO, 32'h07);
		// Every data length with parity and stop count taken from the index, full duplex.
		for (int i = 0; i < 8; i++) begin
			m = 8'hff >> (7 - i);
			i_far.len = i + 1;
			i_far.par_on = i[0];
			i_far.par_even = i[1];
			tx_d = 8'(rnd());
			rx_d = 8'(rnd());
			i_far.got_q.delete();
			apb(1'b1, OFS_CTRL, {27'h0, i[2], i[1], i[0], 2'b11});
			apb(1'b1, OFS_FMT, 32'(i));
			apb(1'b1, OFS_TXDATA, {24'h0, tx_d});
			i_far.send(rx_d, 1'b0, 1'b0, 1'b1);
			wait_q(1);
			`CHK("tx frame", exp_frame(tx_d & m, i[0], i[1]), i_far.got_q[0])
			apb(1'b0, OFS_STATUS, 32'h0);
			`CHK("rx ready", 1'b1, q[ST_RX_BUFFER_READY_FLAG])
			chk_rd(OFS_RXDATA, {24'h0, rx_d & m});
			chk_rd(OFS_RXEMU, {24'h0, rx_d & m});
		end
		// Parity slip, low stop bit and a break; only the break reaches rx_int unmasked.
		i_far.len = 8;
		i_far.par_even = 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0e);
		apb(1'b1, OFS_FMT, 32'h07);
		for (int k = 0; k < 3; k++) begin
			i_far.send(k == 2 ? 8'h00 : 8'h81, 1'b0, k == 0, k == 0);
			chk_rd(OFS_STATUS, {24'h0, err_st[k]});
			`CHK("rx_int", k == 2, rx_int)
			apb(1'b1, OFS_STATUS, 32'h78);
			apb(1'b0, OFS_RXDATA, 32'h0);
		end
		chk_rd(OFS_STATUS, 32'h03);
		// Seventeen characters into the receive queue with the transmitter held off.
		i_far.par_on = 1'b0;
		apb(1'b1, OFS_CTRL, 32'h02);
		apb(1'b1, OFS_INTEN, 32'h03);
		@(posedge ref_clk);
		`CHK("tx_int", 1'b1, tx_int)
		`CHK("rx_int", 1'b0, rx_int)
		for (int k = 0; k < 17; k++) begin
			dat[k] = 8'(rnd());
			i_far.send(dat[k], 1'b0, 1'b0, 1'b1);
		end
		chk_rd(OFS_STATUS, 32'ha7);
		`CHK("rx_int", 1'b1, rx_int)
		for (int k = 0; k < 16; k++) begin
			chk_rd(OFS_RXDATA, {24'h0, dat[k]});
		end
		chk_rd(OFS_STATUS, 32'ha3);
		apb(1'b1, OFS_STATUS, 32'h78);
		// Seventeen characters queued with the transmitter off; the last is dropped.
		apb(1'b1, OFS_CTRL, 32'h00);
		for (int k = 0; k < 17; k++) begin
			dat[k] = 8'(rnd());
			apb(1'b1, OFS_TXDATA, {24'h0, dat[k]});
		end
		chk_rd(OFS_STATUS, 32'h02);
		`CHK("tx_int", 1'b0, tx_int)
		i_far.got_q.delete();
		apb(1'b1, OFS_CTRL, 32'h01);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("tx empty", 1'b0, q[ST_TXEMPT])
		wait_q(16);
		repeat (200) @(posedge ref_clk);
		`CHK("tx count", 16, i_far.got_q.size())
		for (int k = 0; k < 16; k++) begin
			`CHK("tx order", {2'b10, dat[k]}, i_far.got_q[k])
		end
		// Asleep in address mode: a data mark is ignored, an address mark is kept.
		// The transmitter sends its own address mark after the data bits.
		i_far.addr_on = 1'b1;
		i_far.got_q.delete();
		apb(1'b1, OFS_CTRL, 32'h63);
		apb(1'b1, OFS_FMT, 32'h0f);
		tx_d = 8'(rnd());
		apb(1'b1, OFS_TXDATA, {24'h0, tx_d});
		i_far.send(8'h11, 1'b0, 1'b0, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("asleep", 1'b0, q[ST_RX_BUFFER_READY_FLAG])
		i_far.send(8'h22, 1'b1, 1'b0, 1'b1);
		chk_rd(OFS_RXDATA, 32'h22);
		wait_q(1);
		`CHK("tx address mark", {2'b11, tx_d}, i_far.got_q[0])
		// Asleep in idle-line mode: only the first character after a long idle is kept.
		i_far.addr_on = 1'b0;
		apb(1'b1, OFS_CTRL, 32'h42);
		repeat (100) @(posedge ref_clk);
		rx_d = 8'(rnd());
		i_far.send(rx_d, 1'b0, 1'b0, 1'b1);
		i_far.send(8'h5a, 1'b0, 1'b0, 1'b1);
		chk_rd(OFS_RXDATA, {24'h0, rx_d});
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("idle asleep", 1'b0, q[ST_RX_BUFFER_READY_FLAG])
		chk_rd(OFS_WAKE, 32'h01);
		// The start bit of 0x55 is measured into the divisor and the request clears.
		apb(1'b1, OFS_CTRL, 32'h82);
		i_far.send(8'h55, 1'b0, 1'b0, 1'b1);
		chk_rd(OFS_BAUD_LO, 32'h08);
		chk_rd(OFS_CTRL, 32'h02);
		report_and_stop();
	end
endmodule
